/* File: hw/tcs_pkg.sv */
// constants, register map and helper functions shared by the timer set
package tcs_pkg;

    // ==========================================================
    // timer population
    // ==========================================================
    localparam int TCS_NUM_TIMERS = 5;      // index 0 first timer, 1..4 timers two to five
    localparam int TCS_DATA_W = 16;

    // ==========================================================
    // register map (16-bit word index on reg_addr)
    // ==========================================================
    localparam logic [4:0] TCS_TIMER_STRIDE = 5'h03;
    localparam logic [4:0] TCS_OFS_CTRL = 5'h00;
    localparam logic [4:0] TCS_OFS_COUNT = 5'h01;
    localparam logic [4:0] TCS_OFS_PERIOD = 5'h02;
    localparam logic [4:0] TCS_OFS_FLAGS = 5'h0f;
    localparam logic [4:0] TCS_OFS_IRQ_EN = 5'h10;
    localparam logic [4:0] TCS_OFS_IRQ_PRIO = 5'h11;

    // ==========================================================
    // control field positions
    // ==========================================================
    localparam int TCS_BIT_RUN = 15;        // run_enable
    localparam int TCS_BIT_IDLE = 13;       // idle_stop
    localparam int TCS_BIT_GATE = 6;        // gate_accumulate_enable
    localparam int TCS_BIT_PS_LO = 4;       // prescale_select low bit, field is 5:4
    localparam int TCS_BIT_PAIR = 3;        // pair_32bit_mode, lsw-type only
    localparam int TCS_BIT_SYNC = 2;        // ext_clock_sync, first timer only
    localparam int TCS_BIT_CS = 1;          // clock_source_select

    // writable bits per control register kind, the rest read as zero
    localparam logic [15:0] TCS_MASK_FIRST = 16'ha076;
    localparam logic [15:0] TCS_MASK_LSW = 16'ha07a;
    localparam logic [15:0] TCS_MASK_MSW = 16'ha072;

    // ==========================================================
    // values after reset
    // ==========================================================
    localparam logic [15:0] TCS_CTRL_RESET = 16'h0000;
    localparam logic [15:0] TCS_COUNT_RESET = 16'h0000;
    localparam logic [15:0] TCS_PERIOD_RESET = 16'hffff;

    // ==========================================================
    // prescaler terminal counts (ratio minus one)
    // ==========================================================
    localparam logic [7:0] TCS_PS_LAST_1 = 8'h00;
    localparam logic [7:0] TCS_PS_LAST_8 = 8'h07;
    localparam logic [7:0] TCS_PS_LAST_64 = 8'h3f;
    localparam logic [7:0] TCS_PS_LAST_256 = 8'hff;

    // ==========================================================
    // helpers
    // ==========================================================
    function automatic logic [7:0] tcs_ps_last(input logic [1:0] sel);
        unique case (sel)
            2'h3: return TCS_PS_LAST_256;
            2'h2: return TCS_PS_LAST_64;
            2'h1: return TCS_PS_LAST_8;
            2'h0: return TCS_PS_LAST_1;
        endcase
    endfunction

    function automatic logic tcs_is_msw(input int i);
        return (i == 2) || (i == 4);
    endfunction

    function automatic logic [4:0] tcs_reg_addr(input int i, input logic [4:0] ofs);
        return 5'(i) * TCS_TIMER_STRIDE + ofs;
    endfunction

    function automatic logic [15:0] tcs_ctrl_mask(input int i);
        if (i == 0) begin
            return TCS_MASK_FIRST;
        end
        return tcs_is_msw(i) ? TCS_MASK_MSW : TCS_MASK_LSW;
    endfunction

    // one tick of a 16-bit count: {period match, next count}
    function automatic logic [16:0] tcs_step16(input logic [15:0] c, input logic [15:0] p);
        return (c == p) ? {1'b1, TCS_COUNT_RESET} : {1'b0, c + 16'h0001};
    endfunction

endpackage

/* File: hw/tcs_prescale.sv */
// input clock prescaler producing a one-cycle tick every 1, 8, 64 or 256 input ticks
`timescale 1ns/1ps
`default_nettype none
module tcs_prescale
    import tcs_pkg::*;
(
    input wire logic clk,              // instruction clock
    input wire logic sys_rst,          // synchronous reset, high
    input wire logic clr,              // hold the divider empty while the timer is stopped
    input wire logic [1:0] sel,        // prescale_select
    input wire logic tick_in,          // undivided tick
    output logic tick_out              // divided tick, registered
);
    typedef struct packed {
        logic [7:0] cnt;
        logic tick;
    } tcs_ps_s;

    tcs_ps_s s;
    tcs_ps_s next_s;

    // ==========================================================
    // divider
    // ==========================================================
    // a stopped timer restarts with a full prescale period, never a short first one
    always_comb begin
        next_s = s;
        next_s.tick = 1'b0;
        if (clr) begin
            next_s.cnt = '0;
        end else if (tick_in) begin
            if (s.cnt >= tcs_ps_last(sel)) begin
                next_s.cnt = '0;
                next_s.tick = 1'b1;
            end else begin
                next_s.cnt = s.cnt + 8'h01;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign tick_out = s.tick;

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    unity_ratio_a: assert property (!clr && sel == 2'h0 && tick_in |=> tick_out)
        else $error("prescaler 1:1 dropped a tick");
    ratio_count_a: assert property (tick_out |-> $past(s.cnt) == tcs_ps_last($past(sel)))
        else $error("prescaler tick at wrong count");
endmodule // tcs_prescale
`default_nettype wire

/* File: hw/tcs_sync.sv */
// two-stage synchroniser for a tick pulse from the external clock path
`timescale 1ns/1ps
`default_nettype none
module tcs_sync
    import tcs_pkg::*;
(
    input wire logic clk,              // instruction clock
    input wire logic sys_rst,          // synchronous reset, high
    input wire logic pulse_in,         // tick before synchronisation
    output logic pulse_out             // same tick, two cycles later
);
    typedef struct packed {
        logic s1;
        logic s2;
    } tcs_sy_s;

    tcs_sy_s s;
    tcs_sy_s next_s;

    // ==========================================================
    // two flops, the first one read only by the second
    // ==========================================================
    always_comb begin
        next_s.s1 = pulse_in;
        next_s.s2 = s.s1;
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign pulse_out = s.s2;
endmodule // tcs_sync
`default_nettype wire

/* File: hw/tcs_timer_set.sv */
// set of five 16-bit timers with 32-bit pairing, register port and triggers
//
// Our own choices: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module tcs_timer_set
    import tcs_pkg::*;
(
    input wire logic clk,                      // instruction clock, 200 MHz
    input wire logic sys_rst,                  // synchronous reset, high
    input wire logic [4:0] reg_addr,           // register word index
    input wire logic [15:0] reg_wdata,         // write data
    input wire logic reg_we,                   // write strobe
    input wire logic reg_re,                   // read strobe
    output logic [15:0] reg_rdata,             // read data, cycle after reg_re
    input wire logic cpu_idle,                 // device is in idle mode
    input wire logic [4:0] ext_clock_pin,      // external clock / gate per timer
    output logic [4:0] irq_req,                // flag and enable per timer, held low for a paired lsw timer
    output logic [1:0] dma_trigger,            // period match pulse, timers two and three
    output logic adc_trigger                   // period match pulse of timer three
);
    typedef struct packed {
        logic [4:0][15:0] ctrl;
        logic [4:0][15:0] count;
        logic [4:0][15:0] period;
        logic [4:0] flag;
        logic [4:0] ie;
        logic [14:0] prio;                     // irq_priority, three bits per timer
        logic [4:0] pin_q;                     // previous pin sample for edge detection
        logic [15:0] rdata;
        logic [4:0] irq;
        logic [1:0] dma;
        logic adc;
    } tcs_top_s;

    tcs_top_s s;
    tcs_top_s next_s;

    logic [4:0] pair_on;
    logic [4:0] run;
    logic [4:0] active;
    logic [4:0] cs;
    logic [4:0] gate_en;
    logic [4:0] sync_en;
    logic [4:0][1:0] psel;
    logic [4:0] edge_det;
    logic [4:0] ps_in;
    logic [4:0] ps_out;
    logic [4:0] sync_in;
    logic [4:0] sync_out;
    logic [4:0] tick;
    logic [4:0] ev;

    // ==========================================================
    // effective configuration per timer
    // ==========================================================
    // a paired msw timer borrows every lsw control bit, and its own idle_stop counts as well
    always_comb begin : cfg_decode
        int j;
        logic [15:0] gov;
        logic stop_idle;
        j = 0;
        gov = '0;
        stop_idle = 1'b0;
        pair_on[0] = 1'b0;
        pair_on[1] = s.ctrl[1][TCS_BIT_PAIR];
        pair_on[2] = pair_on[1];
        pair_on[3] = s.ctrl[3][TCS_BIT_PAIR];
        pair_on[4] = pair_on[3];
        for (int i = 0; i < TCS_NUM_TIMERS; i++) begin
            j = (tcs_is_msw(i) && pair_on[i]) ? i - 1 : i;
            gov = s.ctrl[j];
            run[i] = gov[TCS_BIT_RUN];
            cs[i] = gov[TCS_BIT_CS];
            gate_en[i] = gov[TCS_BIT_GATE] & ~gov[TCS_BIT_CS];
            sync_en[i] = (i == 0) ? gov[TCS_BIT_SYNC] : 1'b1;
            psel[i] = gov[TCS_BIT_PS_LO +: 2];
            stop_idle = s.ctrl[i][TCS_BIT_IDLE] | gov[TCS_BIT_IDLE];
            active[i] = run[i] & ~(cpu_idle & stop_idle);
            edge_det[i] = ext_clock_pin[j] & ~s.pin_q[j];
            // timer mode ticks on every instruction cycle, gated mode only in cycles where the gate pin is high
            if (!cs[i]) begin
                ps_in[i] = ~gate_en[i] | ext_clock_pin[j];
            end else if (tcs_is_msw(i)) begin
                ps_in[i] = sync_out[i];
            end else begin
                ps_in[i] = edge_det[i];
            end
            sync_in[i] = tcs_is_msw(i) ? edge_det[i] : ps_out[i];
            // unsynchronised first-timer counting skips the two-flop delay
            if (tcs_is_msw(i)) begin
                tick[i] = ps_out[i];
            end else begin
                tick[i] = (cs[i] & sync_en[i]) ? sync_out[i] : ps_out[i];
            end
        end
        // a pair halts in idle when either half asks to, so the lsw half follows the msw half
        if (pair_on[1]) begin
            active[1] = active[2];
        end
        if (pair_on[3]) begin
            active[3] = active[4];
        end
    end

    // ==========================================================
    // prescaler and synchroniser per timer
    // ==========================================================
    for (genvar g = 0; g < TCS_NUM_TIMERS; g++) begin : g_timer
        tcs_prescale u_ps (
            .clk(clk),
            .sys_rst(sys_rst),
            .clr(~active[g]),
            .sel(psel[g]),
            .tick_in(ps_in[g]),
            .tick_out(ps_out[g])
        );
        tcs_sync u_sy (
            .clk(clk),
            .sys_rst(sys_rst),
            .pulse_in(sync_in[g]),
            .pulse_out(sync_out[g])
        );
    end

    // ==========================================================
    // counting, flags, triggers and register port
    // ==========================================================
    // a bus write to a count in the same cycle as a tick wins over the tick
    always_comb begin : next_state
        int lo;
        int hi;
        logic [16:0] st;
        logic [31:0] wide;
        logic [4:0] flag_clr;
        lo = 0;
        hi = 0;
        st = '0;
        wide = '0;
        flag_clr = '0;
        ev = '0;
        next_s = s;
        next_s.pin_q = ext_clock_pin;
        next_s.rdata = '0;
        if (active[0] && tick[0]) begin
            st = tcs_step16(s.count[0], s.period[0]);
            next_s.count[0] = st[15:0];
            ev[0] = st[16];
        end
        for (int p = 0; p < 2; p++) begin
            lo = 1 + 2 * p;
            hi = lo + 1;
            if (pair_on[lo]) begin
                if (active[lo] && tick[lo]) begin
                    // 32-bit match against the period pair, msw above lsw
                    if ({s.count[hi], s.count[lo]} == {s.period[hi], s.period[lo]}) begin
                        next_s.count[hi] = TCS_COUNT_RESET;
                        next_s.count[lo] = TCS_COUNT_RESET;
                        ev[hi] = 1'b1;
                    end else begin
                        wide = {s.count[hi], s.count[lo]} + 32'h0000_0001;
                        next_s.count[hi] = wide[31:16];
                        next_s.count[lo] = wide[15:0];
                    end
                end
            end else begin
                if (active[lo] && tick[lo]) begin
                    st = tcs_step16(s.count[lo], s.period[lo]);
                    next_s.count[lo] = st[15:0];
                    ev[lo] = st[16];
                end
                if (active[hi] && tick[hi]) begin
                    st = tcs_step16(s.count[hi], s.period[hi]);
                    next_s.count[hi] = st[15:0];
                    ev[hi] = st[16];
                end
            end
        end

        // register writes
        if (reg_we && reg_addr == TCS_OFS_FLAGS) begin
            flag_clr = reg_wdata[4:0];
        end
        for (int i = 0; i < TCS_NUM_TIMERS; i++) begin
            if (reg_we && reg_addr == tcs_reg_addr(i, TCS_OFS_CTRL)) begin
                next_s.ctrl[i] = reg_wdata & tcs_ctrl_mask(i);
            end
            if (reg_we && reg_addr == tcs_reg_addr(i, TCS_OFS_COUNT)) begin
                next_s.count[i] = reg_wdata;
            end
            if (reg_we && reg_addr == tcs_reg_addr(i, TCS_OFS_PERIOD)) begin
                next_s.period[i] = reg_wdata;
            end
        end
        if (reg_we && reg_addr == TCS_OFS_IRQ_EN) begin
            next_s.ie = reg_wdata[4:0];
        end
        if (reg_we && reg_addr == TCS_OFS_IRQ_PRIO) begin
            next_s.prio = reg_wdata[14:0];
        end

        // sticky flags, a match in the clearing cycle survives the clear
        next_s.flag = (s.flag & ~flag_clr) | ev;
        // a paired lsw timer never raises its own request
        next_s.irq = next_s.flag & next_s.ie & {1'b0, pair_on[3], 1'b0, pair_on[1], 1'b0}
            ^ (next_s.flag & next_s.ie & {1'b0, pair_on[3], 1'b0, pair_on[1], 1'b0})
            | (next_s.flag & next_s.ie & ~{1'b0, pair_on[3], 1'b0, pair_on[1], 1'b0});
        next_s.dma = {ev[2], ev[1]};
        next_s.adc = ev[2];

        // register reads, answered in the next cycle only
        if (reg_re) begin
            for (int i = 0; i < TCS_NUM_TIMERS; i++) begin
                if (reg_addr == tcs_reg_addr(i, TCS_OFS_CTRL)) begin
                    next_s.rdata = s.ctrl[i];
                end
                if (reg_addr == tcs_reg_addr(i, TCS_OFS_COUNT)) begin
                    next_s.rdata = s.count[i];
                end
                if (reg_addr == tcs_reg_addr(i, TCS_OFS_PERIOD)) begin
                    next_s.rdata = s.period[i];
                end
            end
            if (reg_addr == TCS_OFS_FLAGS) begin
                next_s.rdata = {11'h000, s.flag};
            end
            if (reg_addr == TCS_OFS_IRQ_EN) begin
                next_s.rdata = {11'h000, s.ie};
            end
            if (reg_addr == TCS_OFS_IRQ_PRIO) begin
                next_s.rdata = {1'b0, s.prio};
            end
        end
    end

    // state register with reset values
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s <= '0;
            s.period <= {TCS_NUM_TIMERS{TCS_PERIOD_RESET}};
        end else begin
            s <= next_s;
        end
    end

    assign reg_rdata = s.rdata;
    assign irq_req = s.irq;
    assign dma_trigger = s.dma;
    assign adc_trigger = s.adc;

    // ==========================================================
    // checks
    // ==========================================================
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    logic quiet;
    logic t1_async;
    logic t1_sync;
    logic t1_gated;
    assign quiet = !reg_we && !cpu_idle;
    assign t1_async = active[0] && s.ctrl[0][TCS_BIT_CS] && !s.ctrl[0][TCS_BIT_SYNC]
        && psel[0] == 2'h0;
    assign t1_sync = active[0] && s.ctrl[0][TCS_BIT_CS] && s.ctrl[0][TCS_BIT_SYNC]
        && psel[0] == 2'h0;
    assign t1_gated = active[0] && !s.ctrl[0][TCS_BIT_CS] && s.ctrl[0][TCS_BIT_GATE];

    sequence gate_low_seq;
        (t1_gated && !ext_clock_pin[0] && !reg_we)[*3];
    endsequence

    sequence async_edge_seq;
        t1_async && edge_det[0] && quiet ##1 quiet && s.count[0] != s.period[0];
    endsequence

    sequence sync_edge_seq;
        t1_sync && edge_det[0] && quiet ##1 quiet[*2] ##1 quiet && s.count[0] != s.period[0];
    endsequence

    run_stop_a: assert property (!s.ctrl[0][TCS_BIT_RUN] && !reg_we |=> $stable(s.count[0]))
        else $error("first timer counted while stopped");
    idle_halt_a: assert property (cpu_idle && s.ctrl[0][TCS_BIT_IDLE] && !reg_we
        |=> $stable(s.count[0]))
        else $error("first timer counted in idle with idle_stop set");
    count_step_a: assert property (active[0] && tick[0] && s.count[0] != s.period[0] && !reg_we
        |=> s.count[0] == $past(s.count[0]) + 16'h0001)
        else $error("first timer did not count by one");
    period_wrap_a: assert property (active[0] && tick[0] && s.count[0] == s.period[0] && !reg_we
        |=> s.count[0] == TCS_COUNT_RESET && s.flag[0])
        else $error("first timer missed period match");
    gate_hold_a: assert property (gate_low_seq |=> $stable(s.count[0]))
        else $error("gated timer counted with gate low");
    async_path_a: assert property (async_edge_seq |=> s.count[0] == $past(s.count[0]) + 16'h0001)
        else $error("async counter edge not counted two cycles on");
    sync_path_a: assert property (sync_edge_seq |=> s.count[0] == $past(s.count[0]) + 16'h0001)
        else $error("sync counter edge not counted four cycles on");
    pair_carry_a: assert property (pair_on[1] && active[1] && tick[1] && !reg_we
        && s.count[1] == 16'hffff && {s.count[2], s.count[1]} != {s.period[2], s.period[1]}
        |=> s.count[1] == 16'h0000 && s.count[2] == $past(s.count[2]) + 16'h0001)
        else $error("32-bit carry into msw lost");
    pair_match_a: assert property (pair_on[1] && active[1] && tick[1] && !reg_we
        && {s.count[2], s.count[1]} == {s.period[2], s.period[1]}
        |=> s.count[1] == 16'h0000 && s.count[2] == 16'h0000 && s.flag[2]
        && !irq_req[1])
        else $error("32-bit period match wrong");
    dma_pulse_a: assert property (dma_trigger[0] |-> $past(ev[1]) && !$past(pair_on[1]))
        else $error("dma trigger without timer two match");

    // msw counter path, pairing in idle, request masking and conversion trigger
    sequence msw_edge_seq;
        active[4] && cs[4] && !pair_on[3] && psel[4] == 2'h0 && edge_det[4] && quiet
            ##1 quiet[*2] ##1 quiet && s.count[4] != s.period[4];
    endsequence

    msw_sync_a: assert property (msw_edge_seq
        |=> s.count[4] == $past(s.count[4]) + 16'h0001)
        else $error("msw counter edge not counted four cycles on");
    pair_idle_a: assert property (pair_on[1] && cpu_idle && s.ctrl[2][TCS_BIT_IDLE] && !reg_we
        |=> $stable(s.count[1]) && $stable(s.count[2]))
        else $error("pair counted in idle with msw idle_stop set");
    irq_mask_a: assert property (pair_on[1] |=> !irq_req[1])
        else $error("paired lsw timer raised its own request");
    adc_pulse_a: assert property (adc_trigger |-> dma_trigger[1] && $past(ev[2]))
        else $error("conversion trigger without timer three match");
endmodule // tcs_timer_set
`default_nettype wire

/* File: verification/tcs_pin_src.sv */
// external clock and gate source for the timer pins
`timescale 1ns/1ps
`default_nettype none
module tcs_pin_src
    import tcs_pkg::*;
(
    input wire logic clk,         // instruction clock
    input wire logic [4:0] hold,  // pins held high as a gate
    input wire logic [4:0] tog,   // pins toggled as a clock
    output logic [4:0] pin        // pin levels
);
    logic ph = 1'b0;
    // one rising edge every two cycles; an unused pin is driven low
    always @(posedge clk) begin
        ph <= ~ph;
        pin <= hold | (tog & {5{ph}});
    end
endmodule // tcs_pin_src
`default_nettype wire

/* File: verification/tcs_timer_set_tb.sv */
// self-checking bench for the timer set
`timescale 1ns/1ps
`default_nettype none
module tcs_timer_set_tb
    import tcs_pkg::*;
;
    // ========
    // signals
    // ========
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [4:0] reg_addr = 5'h00;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_we = 1'b0;
    logic reg_re = 1'b0;
    logic cpu_idle = 1'b0;
    logic [4:0] hold = 5'h00;
    logic [4:0] tog = 5'h00;
    logic [4:0] pin, irq_req;
    logic [15:0] reg_rdata, rd_val;
    logic [1:0] dma_trigger;
    logic adc_trigger;
    int mismatches = 0;
    int n_checks = 0;
    int n_adc = 0;
    int n_dma = 0;
    // readable control bits per timer, then one row per first-timer mode
    logic [15:0] mask [5] = '{16'ha076, 16'ha07a, 16'ha072, 16'ha07a, 16'ha072};
    logic [15:0] m_ctrl [6] = '{16'h8040, 16'h8040, 16'h8002, 16'h8006, 16'h8042, 16'h8004};
    logic [15:0] m_lo [6] = '{16'd0, 16'd99, 16'd47, 16'd47, 16'd47, 16'd99};
    int sh [4] = '{0, 3, 6, 8};
    initial begin
        forever #2.5 clk = ~clk;
    end
    tcs_timer_set uut (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata),
        .cpu_idle(cpu_idle), .ext_clock_pin(pin), .irq_req(irq_req),
        .dma_trigger(dma_trigger), .adc_trigger(adc_trigger));
    tcs_pin_src src (.clk(clk), .hold(hold), .tog(tog), .pin(pin));
    // trigger pulses are one cycle, so count them as they pass
    always @(posedge clk) begin
        if (adc_trigger === 1'b1 && dma_trigger[1] === 1'b1) n_adc++;
        if (dma_trigger[0] === 1'b1) n_dma++;
    end
    // ========
    // tasks
    // ========
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_we <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_we <= 1'b0;
    endtask
    task automatic chk_v(input string nm, input logic [15:0] v, lo, hi);
        n_checks++;
        if ((v >= lo && v <= hi) !== 1'b1) begin
            mismatches++;
            $display("mismatch %s expected %h..%h seen %h", nm, lo, hi, v);
        end
    endtask
    // read data stand only in the cycle after the strobe
    task automatic chk(input string nm, input logic [4:0] a, input logic [15:0] lo, hi);
        @(posedge clk);
        reg_re <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_re <= 1'b0;
        #1 rd_val = reg_rdata;
        chk_v(nm, rd_val, lo, hi);
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        #200000;
        mismatches++;
        summarize();
    end
    // ========
    // tests
    // ========
    initial begin
        repeat (6) @(posedge clk);
        sys_rst <= 1'b0;
        chk("period0", 5'h02, 16'hffff, 16'hffff);
        chk("unmapped", 5'h1f, 16'h0000, 16'h0000);
        for (int i = 0; i < 5; i++) begin
            chk("ctrl rst", 5'(3 * i), 16'h0000, 16'h0000);
            wr(5'(3 * i), 16'hffff);
            chk("ctrl bits", 5'(3 * i), mask[i], mask[i]);
            wr(5'(3 * i), 16'h0000);
        end
        $display("test registers done");
        for (int s = 0; s < 4; s++) begin
            wr(5'h01, 16'h0000);
            wr(5'h00, 16'h8000 | 16'(s << 4));
            repeat (600) @(posedge clk);
            wr(5'h00, 16'h0000);
            chk("prescaled", 5'h01, 16'((601 >> sh[s]) - 2), 16'((601 >> sh[s]) + 2));
        end
        $display("test prescale done");
        for (int m = 0; m < 6; m++) begin
            wr(5'h01, 16'h0000);
            hold <= {4'h0, m == 1};
            tog <= {4'h0, m > 1};
            wr(5'h00, m_ctrl[m]);
            repeat (100) @(posedge clk);
            wr(5'h00, 16'h0000);
            chk("mode count", 5'h01, m_lo[m], m_lo[m] + (m > 0 ? 16'd6 : 16'd0));
        end
        $display("test modes done");
        wr(5'h01, 16'h0000);
        hold <= 5'h00;
        tog <= 5'h00;
        cpu_idle <= 1'b1;
        wr(5'h00, 16'ha000);
        repeat (50) @(posedge clk);
        chk("idle halt", 5'h01, 16'd0, 16'd0);
        wr(5'h00, 16'h8000);
        repeat (50) @(posedge clk);
        chk("idle run", 5'h01, 16'd50, 16'd58);
        $display("test idle done");
        @(posedge clk);
        cpu_idle <= 1'b0;
        tog <= 5'h18;
        wr(5'h09, 16'h8002);
        wr(5'h0c, 16'h8002);
        repeat (100) @(posedge clk);
        wr(5'h09, 16'h0000);
        wr(5'h0c, 16'h0000);
        chk("lsw ext", 5'h0a, 16'd47, 16'd53);
        chk("msw ext", 5'h0d, 16'd47, 16'd53);
        $display("test pair counters done");
        wr(TCS_OFS_FLAGS, 16'h001f);
        wr(TCS_OFS_IRQ_EN, 16'h001f);
        wr(5'h08, 16'h0001);
        wr(5'h05, 16'h0004);
        wr(5'h04, 16'hfff8);
        wr(5'h03, 16'h8008);
        repeat (40) @(posedge clk);
        wr(5'h03, 16'h0000);
        chk("msw count", 5'h07, 16'h0000, 16'h0000);
        chk("lsw count", 5'h04, 16'd24, 16'd32);
        chk("flags", TCS_OFS_FLAGS, 16'h0004, 16'h0004);
        chk_v("irq", 16'(irq_req), 16'h0004, 16'h0004);
        chk_v("adc", 16'(n_adc), 16'h0001, 16'h0001);
        chk_v("dma0", 16'(n_dma), 16'h0000, 16'h0000);
        wr(TCS_OFS_FLAGS, 16'h0004);
        chk("flag clr", TCS_OFS_FLAGS, 16'h0000, 16'h0000);
        wr(5'h06, 16'h2000);
        cpu_idle <= 1'b1;
        wr(5'h04, 16'h0000);
        wr(5'h03, 16'h8008);
        repeat (20) @(posedge clk);
        chk("pair idle", 5'h04, 16'h0000, 16'h0000);
        wr(5'h03, 16'h8000);
        repeat (12) @(posedge clk);
        wr(5'h03, 16'h0000);
        chk("lsw flag", TCS_OFS_FLAGS, 16'h0002, 16'h0002);
        chk_v("dma0 run", 16'(n_dma), 16'h0002, 16'h0002);
        chk_v("irq lsw", 16'(irq_req), 16'h0002, 16'h0002);
        $display("test pair done");
        summarize();
    end
endmodule // tcs_timer_set_tb
`default_nettype wire
